// File: core/bpt_status.sv
// Status, flag and error-code register bank of the biphase transceiver.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (R1) Line select bit picks digital or comparator input
// (R2) Transmitter busy bit mirrors transmit active
// (R3) Transmit queue empty set when empty, write clears
// (R4) Software never writes data while queue full
// (R5) Query response flag set in coax, read clears
// (R6) Word ready on valid word; read of last word/error clears
// (R7) Parity error or station 111 end flag
// (R8) Line activity set on edge, 16 idle clears
// (R9) Turnaround set at end; data write/one/reset clear
// (R10) Query seen flag set in coax, read clears
// (R11) Receiver busy from start until end or error
// (R12) Auto reply flag set in coax, read clears
// (R13) Error summary set on error; code read clears
// (R14) Receive queue full at three words held
// (R15) Bad ending error in coax, mux, byte modes
// (R16) Lost midbit error on missing mid transition
// (R17) Overrun when full and another word arrives
// (R18) Word odd check error on bad parity
// (R19) Preempted error when transmit starts over receive, repeat bit clear
// (R20) Data read pops, write pushes, flags follow
module bpt_status
  import bpt_pkg::*;
#(
  parameter int unsigned RXQ_DEPTH = RXQ_WORDS,
  parameter int unsigned TXQ_DEPTH = TXQ_WORDS
) (
  // Clock and reset.
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  // Register port.
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // Line pins, asynchronous to ref_clk_i.
  input  wire logic              line_data_in_i,
  input  wire logic              line_cmp_in_i,
  input  wire logic              tx_bit_clock_i,
  // Frame decoder side.
  output logic                   rx_line_o,
  input  wire bpt_rx_evt_s       rx_evt_i,
  input  wire logic              rx_word_strobe_i,
  input  wire logic [7:0]        rx_word_data_i,
  input  wire logic              rx_byte_par_err_i,
  input  wire logic              rx_station_all_i,
  input  wire logic              rx_cmd_poll_i,
  input  wire logic              rx_cmd_poll_ack_i,
  input  wire logic              rx_cmd_auto_resp_i,
  // Serialiser side.
  input  wire logic              tx_active_pin_i,
  output logic                   tx_word_valid_o,
  input  wire logic              tx_word_take_i,
  output logic      [7:0]        tx_word_o
);

  localparam int unsigned RCW = $clog2(RXQ_DEPTH + 1);
  localparam int unsigned TCW = $clog2(TXQ_DEPTH + 1);
  localparam int unsigned RIW = (RXQ_DEPTH > 1) ? $clog2(RXQ_DEPTH) : 1;
  localparam int unsigned TIW = (TXQ_DEPTH > 1) ? $clog2(TXQ_DEPTH) : 1;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  function automatic int unsigned wrap_inc(input int unsigned p, input int unsigned depth);
    return (p + 1 == depth) ? 0 : p + 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register port decode.

  logic [7:0] tx_ctrl_r;
  logic [7:0] xcvr_ctrl_r;
  wire        wr_data  = reg_wr_i && (reg_addr_i == OFF_DATA);
  wire        rd_data  = reg_rd_i && (reg_addr_i == OFF_DATA);
  wire        rd_err   = reg_rd_i && (reg_addr_i == OFF_ERR_CODE);
  wire        wr_flag  = reg_wr_i && (reg_addr_i == OFF_CMD_FLAG);
  wire        wr_tcr   = reg_wr_i && (reg_addr_i == OFF_TX_CTRL);
  wire        wr_xcr   = reg_wr_i && (reg_addr_i == OFF_XCVR_CTRL);
  wire        transceiver_reset_bit     = xcvr_ctrl_r[XCR_RESET];
  wire        repeat_allow_bit = xcvr_ctrl_r[XCR_REPEAT];
  wire        line_input_select = tx_ctrl_r[TCR_LINE_SEL];
  wire bpt_mode_e mode = bpt_mode_e'(xcvr_ctrl_r[XCR_MODE_LSB +: 2]);
  wire        mode_coax   = (mode == BPT_MODE_COAX);
  wire        mode_twinax = (mode == BPT_MODE_TWINAX);

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      tx_ctrl_r   <= TCR_RESET_VAL;
      xcvr_ctrl_r <= XCR_RESET_VAL;
    end else begin
      if (wr_tcr) tx_ctrl_r <= reg_wdata_i;
      if (wr_xcr) xcvr_ctrl_r <= reg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line input synchronisers and line activity.

  // The source is picked before the synchroniser, so a change of the select bit
  // may look like one line transition and briefly raise the activity flag.
  wire        line_raw = line_input_select ? line_cmp_in_i : line_data_in_i; // [R1]
  logic [SYNC_STAGES-1:0] line_sync_r;
  logic [SYNC_STAGES-1:0] tx_bit_clock_sync_r;
  logic       line_r;
  logic       tx_bit_clock_r;
  logic [4:0] idle_cnt_r;
  logic       line_act_r;

  wire line_agree = (line_sync_r[1] == line_sync_r[2]);
  wire line_edge  = line_agree && (line_sync_r[2] != line_r);
  wire tx_bit_clock_agree = (tx_bit_clock_sync_r[1] == tx_bit_clock_sync_r[2]);
  wire tx_bit_clock_rise  = tx_bit_clock_agree && tx_bit_clock_sync_r[2] && !tx_bit_clock_r;
  wire [4:0] idle_cnt_nxt = line_edge ? 5'h00 :
                            (tx_bit_clock_rise && (idle_cnt_r != LINE_IDLE_CLKS)) ?
                            5'(idle_cnt_r + 5'h01) : idle_cnt_r;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      line_sync_r <= '0;
      tx_bit_clock_sync_r <= '0;
      line_r      <= 1'b0;
      tx_bit_clock_r      <= 1'b0;
      idle_cnt_r  <= 5'h00;
      line_act_r  <= 1'b0;
    end else begin
      line_sync_r <= {line_sync_r[1:0], line_raw};
      tx_bit_clock_sync_r <= {tx_bit_clock_sync_r[1:0], tx_bit_clock_i};
      if (line_agree) line_r <= line_sync_r[2];
      if (tx_bit_clock_agree) tx_bit_clock_r <= tx_bit_clock_sync_r[2];
      idle_cnt_r  <= idle_cnt_nxt;
      line_act_r  <= line_edge ? 1'b1 : (idle_cnt_nxt == LINE_IDLE_CLKS) ? 1'b0 : line_act_r; // [R8]
    end
  end

  assign rx_line_o = line_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit queue.

  logic [7:0]     txq_mem_r [TXQ_DEPTH];
  logic [TIW-1:0] txq_wp_r;
  logic [TIW-1:0] txq_rp_r;
  logic [TCW-1:0] txq_cnt_r;
  wire  txq_full_bit  = (txq_cnt_r == TCW'(TXQ_DEPTH));
  wire  txq_empty_bit = (txq_cnt_r == '0);                            // [R3]
  // A write while full is dropped; software is expected to check the full bit.
  wire  txq_push = wr_data && !txq_full_bit && !transceiver_reset_bit;                 // [R4] [R20]
  wire  txq_pop  = tx_word_valid_o && tx_word_take_i;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || transceiver_reset_bit) begin
      txq_wp_r  <= '0;
      txq_rp_r  <= '0;
      txq_cnt_r <= '0;
    end else begin
      if (txq_push) txq_wp_r <= TIW'(wrap_inc(32'(txq_wp_r), TXQ_DEPTH));
      if (txq_pop)  txq_rp_r <= TIW'(wrap_inc(32'(txq_rp_r), TXQ_DEPTH));
      txq_cnt_r <= TCW'(txq_cnt_r + TCW'(txq_push) - TCW'(txq_pop));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (txq_push) txq_mem_r[txq_wp_r] <= reg_wdata_i;
  end

  assign tx_word_valid_o = !txq_empty_bit;
  assign tx_word_o       = txq_mem_r[txq_rp_r];

  ////////////////////////////////////////////////////////////////////////////////
  // Receive queue and word flags.

  bpt_rx_word_s   rxq_mem_r [RXQ_DEPTH];
  logic [RIW-1:0] rxq_wp_r;
  logic [RIW-1:0] rxq_rp_r;
  logic [RCW-1:0] rxq_cnt_r;
  wire  rxq_full_bit = (rxq_cnt_r == RCW'(RXQ_DEPTH));                // [R14]
  wire  rxq_push     = rx_word_strobe_i && !rxq_full_bit && !transceiver_reset_bit;
  wire  rxq_pop      = rd_data && (rxq_cnt_r != '0) && !transceiver_reset_bit;         // [R20]
  wire  overrun      = rx_word_strobe_i && rxq_full_bit;              // [R17]

  // Flags are captured with the word so that they advance with each pop.
  bpt_rx_word_s rx_in;
  assign rx_in.data       = rx_word_data_i;
  assign rx_in.par_or_end = mode_twinax ? rx_station_all_i : rx_byte_par_err_i; // [R7]
  assign rx_in.auto_reply = mode_coax && rx_cmd_auto_resp_i;         // [R12]
  assign rx_in.query_resp = mode_coax && rx_cmd_poll_ack_i;          // [R5]
  assign rx_in.query_seen = mode_coax && rx_cmd_poll_i;              // [R10]

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || transceiver_reset_bit) begin
      rxq_wp_r  <= '0;
      rxq_rp_r  <= '0;
      rxq_cnt_r <= '0;
    end else begin
      if (rxq_push) rxq_wp_r <= RIW'(wrap_inc(32'(rxq_wp_r), RXQ_DEPTH));
      if (rxq_pop)  rxq_rp_r <= RIW'(wrap_inc(32'(rxq_rp_r), RXQ_DEPTH));
      rxq_cnt_r <= RCW'(rxq_cnt_r + RCW'(rxq_push) - RCW'(rxq_pop));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rxq_push) rxq_mem_r[rxq_wp_r] <= rx_in;
  end

  wire bpt_rx_word_s rx_head = rxq_mem_r[rxq_rp_r];

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver state, errors and sticky flags.

  logic       word_ready_r;
  logic       rx_busy_r;
  logic       rx_error_r;
  logic       turn_r;
  logic [4:0] ecr_r;

  // A write that starts an idle transmitter cuts off an active receiver unless the repeat bit is set.
  wire preempt    = wr_data && !tx_active_pin_i && txq_empty_bit
                    && rx_busy_r && !repeat_allow_bit;                // [R19]
  wire bad_ending = rx_evt_i.bad_ending && !mode_twinax;              // [R15]
  wire [4:0] err_set;
  assign err_set[ECR_OVERRUN]     = overrun;
  assign err_set[ECR_WORD_ODD]    = rx_evt_i.word_odd;                // [R18]
  assign err_set[ECR_BAD_ENDING]  = bad_ending;
  assign err_set[ECR_LOST_MIDBIT] = rx_evt_i.lost_midbit;             // [R16]
  assign err_set[ECR_PREEMPTED]   = preempt;
  wire err_any = |err_set;

  // New words and new events win over a clear in the same cycle.
  wire word_ready_nxt = rxq_push ? 1'b1 :
                        err_any ? 1'b0 :
                        rxq_pop ? (rxq_cnt_r > RCW'(1)) : word_ready_r; // [R6]
  wire rx_busy_nxt    = rx_evt_i.start_ok ? 1'b1 :
                        (rx_evt_i.end_msg || err_any) ? 1'b0 : rx_busy_r; // [R11]
  wire turn_clr       = wr_data || (wr_flag && reg_wdata_i[NCF_TURNAROUND]);
  wire turn_nxt       = rx_evt_i.end_msg ? 1'b1 : turn_clr ? 1'b0 : turn_r; // [R9]
  wire rx_error_nxt   = err_any ? 1'b1 : rd_err ? 1'b0 : rx_error_r;  // [R13]
  wire [4:0] ecr_nxt  = err_set | (rd_err ? 5'h00 : ecr_r);           // [R15] [R16] [R18]

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i || transceiver_reset_bit) begin
      word_ready_r <= 1'b0;
      rx_busy_r    <= 1'b0;
      rx_error_r   <= 1'b0;
      turn_r       <= 1'b0;                                           // [R9]
      ecr_r        <= 5'h00;
    end else begin
      word_ready_r <= word_ready_nxt;
      rx_busy_r    <= rx_busy_nxt;
      rx_error_r   <= rx_error_nxt;
      turn_r       <= turn_nxt;
      ecr_r        <= ecr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  wire [7:0] tsr_val = {txq_full_bit, tx_active_pin_i, rx_error_r, rx_busy_r,
                        word_ready_r, 3'h0};                          // [R2]
  wire       head_ok = word_ready_r;
  wire [7:0] ncf_val = {txq_empty_bit, rxq_full_bit, line_act_r, turn_r,
                        head_ok && rx_head.par_or_end, head_ok && rx_head.auto_reply,
                        head_ok && rx_head.query_resp, head_ok && rx_head.query_seen};
  wire [7:0] data_val = (rxq_cnt_r != '0) ? rx_head.data : 8'h00;
  wire [7:0] rd_mux  = (reg_addr_i == OFF_TX_RX_STATUS) ? tsr_val :
                       (reg_addr_i == OFF_CMD_FLAG)     ? ncf_val :
                       (reg_addr_i == OFF_ERR_CODE)     ? {3'h0, ecr_r} :
                       (reg_addr_i == OFF_DATA)         ? data_val :
                       (reg_addr_i == OFF_TX_CTRL)      ? tx_ctrl_r :
                       (reg_addr_i == OFF_XCVR_CTRL)    ? xcvr_ctrl_r : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) reg_rdata_o <= 8'h00;
    else         reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_tx_busy_read: assert property ( // [R2]
    reg_rd_i && reg_addr_i == OFF_TX_RX_STATUS |=>
      reg_rdata_o[TSR_TX_BUSY] == $past(tx_active_pin_i))
    else $error("tx busy bit does not follow transmit active");

  chk_txq_empty_clr: assert property ( // [R3]
    wr_data && !transceiver_reset_bit && !txq_full_bit |=> !txq_empty_bit ##0 tx_word_valid_o)
    else $error("data write left transmit queue empty");

  chk_line_act_idle: assert property ( // [R8]
    line_edge |=> line_act_r ##0 (idle_cnt_r == 5'h00))
    else $error("line activity not raised on edge");

  chk_line_act_drop: assert property ( // [R8]
    idle_cnt_r == LINE_IDLE_CLKS |-> !line_act_r)
    else $error("line activity still set after idle periods");

  chk_turn_set: assert property ( // [R9]
    rx_evt_i.end_msg && !transceiver_reset_bit |=> turn_r)
    else $error("turnaround not set on end of message");

  chk_rx_busy_span: assert property ( // [R11]
    rx_evt_i.start_ok && !transceiver_reset_bit ##1 !(rx_evt_i.end_msg || err_any || transceiver_reset_bit) |=> rx_busy_r)
    else $error("receiver busy dropped without cause");

  chk_err_sum_clr: assert property ( // [R13]
    rd_err && !err_any && !transceiver_reset_bit |=> !rx_error_r ##0 (ecr_r == 5'h00))
    else $error("error summary not cleared by code read");

  chk_rxq_full_read: assert property ( // [R14]
    reg_rd_i && reg_addr_i == OFF_CMD_FLAG && rxq_cnt_r == RCW'(RXQ_DEPTH) |=>
      reg_rdata_o[NCF_RXQ_FULL])
    else $error("receive queue full not reported");

  chk_overrun_set: assert property ( // [R17]
    rx_word_strobe_i && rxq_full_bit && !transceiver_reset_bit |=> ecr_r[ECR_OVERRUN] && rx_error_r)
    else $error("overrun not flagged");

  chk_preempt_set: assert property ( // [R19]
    preempt && !transceiver_reset_bit && !rx_evt_i.start_ok && !rxq_push |=>
      ecr_r[ECR_PREEMPTED] && !rx_busy_r && !word_ready_r)
    else $error("preempted receiver not flagged");

  chk_ready_pop: assert property ( // [R6]
    rxq_pop && !rxq_push && !err_any && rxq_cnt_r == RCW'(1) |=> !word_ready_r)
    else $error("word ready stays after last word read");

  chk_line_sel_data: assert property ( // [R1]
    !line_input_select |=> line_sync_r[0] == $past(line_data_in_i))
    else $error("digital line input not selected");

  chk_line_sel_cmp: assert property ( // [R1]
    line_input_select |=> line_sync_r[0] == $past(line_cmp_in_i))
    else $error("comparator line input not selected");

  chk_txq_full_drop: assert property ( // [R4]
    wr_data && txq_full_bit && !tx_word_take_i && !transceiver_reset_bit |=> txq_cnt_r == TCW'(TXQ_DEPTH))
    else $error("write to full transmit queue not dropped");

  chk_ready_on_push: assert property ( // [R6]
    rxq_push |=> word_ready_r)
    else $error("word ready not raised by received word");

  chk_ready_on_error: assert property ( // [R6]
    err_any && !rxq_push && !transceiver_reset_bit |=> !word_ready_r)
    else $error("word ready not cleared by receive error");

  chk_turn_clear: assert property ( // [R9]
    turn_clr && !rx_evt_i.end_msg |=> !turn_r)
    else $error("turnaround not cleared");

  chk_rx_busy_clr: assert property ( // [R11]
    (rx_evt_i.end_msg || err_any) && !rx_evt_i.start_ok |=> !rx_busy_r)
    else $error("receiver busy not cleared by end or error");

  chk_err_sum_set: assert property ( // [R13]
    err_any && !transceiver_reset_bit |=> rx_error_r)
    else $error("error summary not raised");

  chk_bad_end_set: assert property ( // [R15]
    rx_evt_i.bad_ending && mode != BPT_MODE_TWINAX && !transceiver_reset_bit |=> ecr_r[ECR_BAD_ENDING])
    else $error("bad ending error not flagged");

  chk_midbit_set: assert property ( // [R16]
    rx_evt_i.lost_midbit && !transceiver_reset_bit |=> ecr_r[ECR_LOST_MIDBIT])
    else $error("lost midbit error not flagged");

  chk_odd_word_set: assert property ( // [R18]
    rx_evt_i.word_odd && !transceiver_reset_bit |=> ecr_r[ECR_WORD_ODD])
    else $error("word odd check error not flagged");

  chk_soft_reset_clr: assert property ( // [R9] [R13]
    transceiver_reset_bit |=> rxq_cnt_r == '0 && txq_cnt_r == '0 && ecr_r == 5'h00 && !turn_r)
    else $error("soft reset left queues or flags set");

endmodule

`default_nettype wire

// File: core/bpt_pkg.sv
// Shared constants, types and register map of the biphase transceiver status block.
package bpt_pkg;

  // Register indices on the plain register port.
  localparam int unsigned  ADDR_W           = 3;
  localparam int unsigned  DATA_W           = 8;
  localparam logic [2:0]   OFF_TX_RX_STATUS = 3'h0;
  localparam logic [2:0]   OFF_CMD_FLAG     = 3'h1;
  localparam logic [2:0]   OFF_ERR_CODE     = 3'h2;
  localparam logic [2:0]   OFF_DATA         = 3'h3;
  localparam logic [2:0]   OFF_TX_CTRL      = 3'h4;
  localparam logic [2:0]   OFF_XCVR_CTRL    = 3'h5;

  // Status register bit positions.
  localparam int unsigned  TSR_TXQ_FULL     = 7;
  localparam int unsigned  TSR_TX_BUSY      = 6;
  localparam int unsigned  TSR_RX_ERROR     = 5;
  localparam int unsigned  TSR_RX_BUSY      = 4;
  localparam int unsigned  TSR_WORD_READY   = 3;

  // Command and flag register bit positions.
  localparam int unsigned  NCF_TXQ_EMPTY    = 7;
  localparam int unsigned  NCF_RXQ_FULL     = 6;
  localparam int unsigned  NCF_LINE_ACT     = 5;
  localparam int unsigned  NCF_TURNAROUND   = 4;
  localparam int unsigned  NCF_PAR_OR_END   = 3;
  localparam int unsigned  NCF_AUTO_REPLY   = 2;
  localparam int unsigned  NCF_QUERY_RESP   = 1;
  localparam int unsigned  NCF_QUERY_SEEN   = 0;

  // Error code register bit positions.
  localparam int unsigned  ECR_OVERRUN      = 4;
  localparam int unsigned  ECR_WORD_ODD     = 3;
  localparam int unsigned  ECR_BAD_ENDING   = 2;
  localparam int unsigned  ECR_LOST_MIDBIT  = 1;
  localparam int unsigned  ECR_PREEMPTED    = 0;

  // Control bit positions and reset values.
  localparam int unsigned  TCR_LINE_SEL     = 5;
  localparam int unsigned  XCR_RESET        = 7;
  localparam int unsigned  XCR_REPEAT       = 5;
  localparam int unsigned  XCR_MODE_LSB     = 0;
  localparam logic [7:0]   TCR_RESET_VAL    = 8'h00;
  localparam logic [7:0]   XCR_RESET_VAL    = 8'h00;

  // Depths and counts.
  localparam int unsigned  RXQ_WORDS        = 3;
  localparam int unsigned  TXQ_WORDS        = 3;
  localparam logic [4:0]   LINE_IDLE_CLKS   = 5'h10;
  localparam int unsigned  SYNC_STAGES      = 3;

  typedef enum logic [1:0] {
    BPT_MODE_COAX   = 2'h0,
    BPT_MODE_MUX    = 2'h1,
    BPT_MODE_TWINAX = 2'h3,
    BPT_MODE_BYTE   = 2'h2
  } bpt_mode_e;

  // One received word and the flags that travel with it.
  typedef struct packed {
    logic [7:0] data;
    logic       par_or_end;
    logic       auto_reply;
    logic       query_resp;
    logic       query_seen;
  } bpt_rx_word_s;

  // Per-cycle events from the frame decoder.
  typedef struct packed {
    logic start_ok;
    logic end_msg;
    logic bad_ending;
    logic lost_midbit;
    logic word_odd;
  } bpt_rx_evt_s;

endpackage

// File: verification/bpt_line_partner.sv
// Model of the serialiser and bit clock on the far side of the status block.
`timescale 1ns/100ps
`default_nettype none
module bpt_line_partner (
  // Clock.
  input  wire logic       ref_clk_i,
  // Serialiser handshake.
  input  wire logic       tx_word_valid_i,
  input  wire logic [7:0] tx_word_i,
  input  wire logic       stall_i,
  output logic            tx_word_take_o,
  output logic            tx_active_pin_o,
  output logic            tx_bit_clock_o
);
  logic [7:0] got [0:7];
  logic [2:0] n_r = 3'h0;
  logic [4:0] busy_r = 5'h00;

  // The bit clock is the transceiver's own clock, so it runs free.
  initial tx_bit_clock_o = 1'b0;
  always #62.5 tx_bit_clock_o = ~tx_bit_clock_o;

  assign tx_active_pin_o = (busy_r != 5'h00);

  // A word is taken only while idle, so each word gets a full send time.
  initial tx_word_take_o = 1'b0;
  always @(posedge ref_clk_i) begin
    tx_word_take_o <= 1'b0;
    if (busy_r != 5'h00) begin
      busy_r <= busy_r - 5'h01;
    end else if (tx_word_valid_i && !stall_i && !tx_word_take_o) begin
      tx_word_take_o <= 1'b1;
    end
    if (tx_word_take_o && tx_word_valid_i) begin
      got[n_r] <= tx_word_i;
      n_r      <= n_r + 3'h1;
      busy_r   <= 5'h18;
    end
  end
endmodule
`default_nettype wire

// File: verification/bpt_status_test.sv
// Self-checking bench of the biphase transceiver status register bank.
`timescale 1ns/100ps
`default_nettype none
module bpt_status_test
  import bpt_pkg::*;
;
  logic              ref_clk_i = 1'b0;
  logic              nrst_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic              reg_wr_i = 1'b0;
  logic              reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic              data_pin = 1'b0;
  logic              cmp_pin = 1'b0;
  logic              tx_bit_clock;
  logic              rx_line_o;
  bpt_rx_evt_s       evt = '0;
  logic              wstb = 1'b0;
  logic [7:0]        wdata = 8'h00;
  logic [4:0]        wflag = 5'h00;
  logic              tx_active_pin;
  logic              tx_valid;
  logic              tx_take;
  logic              stall = 1'b0;
  logic [7:0]        tx_word;
  logic [7:0]        d;
  int                mismatches = 0;
  int                comparisons = 0;
  int                k;
  logic [7:0]        ecr_exp [0:2] = '{8'h04, 8'h02, 8'h08};
  logic [4:0]        evt_err [0:2] = '{5'h04, 5'h02, 5'h01};
  logic [7:0]        txw [0:2] = '{8'h5a, 8'ha5, 8'h3c};

  always #5 ref_clk_i = ~ref_clk_i;

  bpt_status bpt_status_i (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .line_data_in_i(data_pin), .line_cmp_in_i(cmp_pin),
    .tx_bit_clock_i(tx_bit_clock), .rx_line_o(rx_line_o), .rx_evt_i(evt),
    .rx_word_strobe_i(wstb), .rx_word_data_i(wdata), .rx_byte_par_err_i(wflag[4]),
    .rx_station_all_i(wflag[3]), .rx_cmd_poll_i(wflag[2]), .rx_cmd_poll_ack_i(wflag[1]),
    .rx_cmd_auto_resp_i(wflag[0]), .tx_active_pin_i(tx_active_pin), .tx_word_valid_o(tx_valid),
    .tx_word_take_i(tx_take), .tx_word_o(tx_word)
  );

  bpt_line_partner bpt_line_partner_i (
    .ref_clk_i(ref_clk_i), .tx_word_valid_i(tx_valid), .tx_word_i(tx_word),
    .stall_i(stall), .tx_word_take_o(tx_take), .tx_active_pin_o(tx_active_pin),
    .tx_bit_clock_o(tx_bit_clock)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= v;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge ref_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask

  task automatic rc(input logic [2:0] a, input logic [7:0] exp);
    rd(a, d);
    check(d, exp);
  endtask

  task automatic pulse(input logic [4:0] e);
    @(posedge ref_clk_i);
    evt <= bpt_rx_evt_s'(e);
    @(posedge ref_clk_i);
    evt <= '0;
  endtask

  // Flags are {byte parity, station all, poll, poll ack, auto response}.
  task automatic word(input logic [7:0] v, input logic [4:0] f);
    @(posedge ref_clk_i);
    wstb  <= 1'b1;
    wdata <= v;
    wflag <= f;
    @(posedge ref_clk_i);
    wstb <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(4);
    nrst_i <= 1'b1;
    rc(OFF_TX_RX_STATUS, 8'h00);
    rc(OFF_CMD_FLAG, 8'h80);
    rc(OFF_ERR_CODE, 8'h00);
    rc(OFF_TX_CTRL, TCR_RESET_VAL);
    wr(3'h6, 8'hff);
    rc(3'h6, 8'h00);
    word(8'h11, 5'h04);
    word(8'h22, 5'h02);
    word(8'h33, 5'h11);
    rc(OFF_TX_RX_STATUS, 8'h08);
    rc(OFF_CMD_FLAG, 8'hc1);
    rc(OFF_DATA, 8'h11);
    rc(OFF_CMD_FLAG, 8'h82);
    rc(OFF_DATA, 8'h22);
    rc(OFF_CMD_FLAG, 8'h8c);
    word(8'h44, 5'h00);
    word(8'h55, 5'h00);
    word(8'h66, 5'h00);
    rc(OFF_TX_RX_STATUS, 8'h20);
    rc(OFF_ERR_CODE, 8'h10);
    rc(OFF_TX_RX_STATUS, 8'h00);
    for (k = 0; k < 4; k++) begin
      rc(OFF_DATA, (k < 3) ? 8'h33 + 8'(k * 17) : 8'h00);
    end
    wr(OFF_XCVR_CTRL, 8'h03);
    word(8'h77, 5'h0c);
    rc(OFF_CMD_FLAG, 8'h88);
    rc(OFF_DATA, 8'h77);
    pulse(5'h04);
    rc(OFF_ERR_CODE, 8'h00);
    wr(OFF_XCVR_CTRL, 8'h02);
    pulse(5'h04);
    rc(OFF_ERR_CODE, 8'h04);
    wr(OFF_XCVR_CTRL, 8'h01);
    word(8'haa, 5'h1f);
    rc(OFF_CMD_FLAG, 8'h88);
    rc(OFF_DATA, 8'haa);
    wr(OFF_XCVR_CTRL, 8'h00);
    for (k = 0; k < 3; k++) begin
      pulse(5'h10);
      rc(OFF_TX_RX_STATUS, 8'h10);
      pulse(evt_err[k]);
      rc(OFF_TX_RX_STATUS, 8'h20);
      rc(OFF_ERR_CODE, ecr_exp[k]);
      rc(OFF_ERR_CODE, 8'h00);
    end
    pulse(5'h10);
    pulse(5'h08);
    rc(OFF_TX_RX_STATUS, 8'h00);
    rc(OFF_CMD_FLAG, 8'h90);
    wr(OFF_CMD_FLAG, 8'h10);
    rc(OFF_CMD_FLAG, 8'h80);
    pulse(5'h08);
    stall <= 1'b1;
    wr(OFF_DATA, txw[0]);
    rc(OFF_CMD_FLAG, 8'h00);
    for (k = 1; k < 3; k++) begin
      rd(OFF_TX_RX_STATUS, d);
      if (d[TSR_TXQ_FULL] === 1'b0) begin
        wr(OFF_DATA, txw[k]);
      end
    end
    rc(OFF_TX_RX_STATUS, 8'h80);
    stall <= 1'b0;
    idle(5);
    rc(OFF_TX_RX_STATUS, 8'h40);
    idle(100);
    rc(OFF_TX_RX_STATUS, 8'h00);
    rc(OFF_CMD_FLAG, 8'h80);
    for (k = 0; k < 3; k++) begin
      check(bpt_line_partner_i.got[k], txw[k]);
    end
    pulse(5'h10);
    wr(OFF_DATA, 8'h01);
    rc(OFF_ERR_CODE, 8'h01);
    wr(OFF_XCVR_CTRL, 8'h20);
    idle(40);
    pulse(5'h10);
    wr(OFF_DATA, 8'h02);
    rc(OFF_ERR_CODE, 8'h00);
    word(8'h99, 5'h00);
    pulse(5'h08);
    pulse(5'h02);
    idle(40);
    wr(OFF_XCVR_CTRL, 8'h80);
    wr(OFF_XCVR_CTRL, 8'h00);
    rc(OFF_TX_RX_STATUS, 8'h00);
    rc(OFF_CMD_FLAG, 8'h80);
    rc(OFF_ERR_CODE, 8'h00);
    rc(OFF_DATA, 8'h00);
    data_pin <= 1'b1;
    idle(5);
    check({7'h00, rx_line_o}, 8'h01);
    wr(OFF_TX_CTRL, 8'h20);
    idle(5);
    check({7'h00, rx_line_o}, 8'h00);
    rc(OFF_TX_CTRL, 8'h20);
    cmp_pin <= 1'b1;
    idle(5);
    check({7'h00, rx_line_o}, 8'h01);
    rc(OFF_CMD_FLAG, 8'ha0);
    idle(165);
    rc(OFF_CMD_FLAG, 8'ha0);
    idle(60);
    rc(OFF_CMD_FLAG, 8'h80);
    summarize();
  end

  // The whole sequence needs about six hundred cycles; ten thousand means a hang.
  initial begin
    #100000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
